// ==== logic/prl_defines.svh ====
// constants for the pin routing lock block
// assumes an 8-bit register write port from the cpu core
`ifndef PRL_DEFINES_SVH
`define PRL_DEFINES_SVH
`define PRL_KEY_FIRST   8'h55
`define PRL_KEY_SECOND  8'hAA
`define PRL_FLAG_BIT    0
`define PRL_SEL_WIDTH   6
`define PRL_NUM_IN      16
`define PRL_NUM_OUT     16
`define PRL_IN_SEL_W    4
`define PRL_OUT_SEL_W   4
`define PRL_SEL_DEFAULT 6'h00
`define PRL_FLAG_RESET  1'b0
`endif

// ==== logic/prl_lock.sv ====
// pin routing lock: key sequence, lock flag, one-way option, selections
// assumes core writes arrive as single-cycle strobes on clock
// assumes resetn is asserted together with por_n at power-up
// sleep stops the clock only; no state here is cleared by it
//
// What this block does
// - lock flag set blocks every routing selection write
// - flag change needs 55h then AAh written first
// - only single-bit set or clear of bit 0 changes flag
// - one-way option allows one clear and one set after it per reset
// - sleep leaves routing selections unchanged
// - power-on reset restores default routing selections
// - other resets keep routing selections
// - any device reset removes one-way restriction
// - bus clock and data may route to any pin
`timescale 1ns/1ps
`include "prl_defines.svh"
module prl_lock (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  por_n,
  input  wire logic                  one_way_en,
  input  wire prl_pkg::prl_lock_wr_t lock_wr,
  input  wire prl_pkg::prl_sel_wr_t  sel_wr,
  output logic                       routing_lock_flag,
  output logic                       sel_write_refused,
  output logic [`PRL_IN_SEL_W*`PRL_SEL_WIDTH-1:0] in_sel,
  output logic [`PRL_IN_SEL_W*`PRL_SEL_WIDTH-1:0] out_sel
);
  prl_pkg::prl_seq_t seq;
  prl_pkg::prl_seq_t next_seq;
  prl_pkg::prl_ow_t  ow;
  prl_pkg::prl_ow_t  next_ow;
  logic              next_flag;
  logic              next_refused;
  logic              any_wr;
  logic              is_first_key;
  logic              is_second_key;
  logic              flag_op_ok;
  logic              may_clear;
  logic              may_set;
  logic              sel_ok;
  logic              in_wr;
  logic              out_wr;

  // bit operations carry a one-hot mask; only bit 0 reaches the flag
  function automatic logic bit0_only(input logic [7:0] d);
    bit0_only = d == 8'h01;
  endfunction : bit0_only

  // a key only counts when written as a whole byte
  function automatic logic full_key(input prl_pkg::prl_lock_wr_t w,
                                    input logic [7:0]            key);
    full_key = w.full_wr && w.data == key;
  endfunction : full_key

  // key decode, shared by every state of the sequence
  always_comb begin
    any_wr        = lock_wr.full_wr | lock_wr.bit_set | lock_wr.bit_clr;
    is_first_key  = full_key(lock_wr, `PRL_KEY_FIRST);
    is_second_key = full_key(lock_wr, `PRL_KEY_SECOND);
  end

  // key sequence; any other write except a repeated 55h drops back to idle
  // cycles with no lock write keep the state, so keys may be spaced
  always_comb begin
    next_seq = seq;
    if (any_wr) begin
      unique case (seq)
        prl_pkg::PRL_IDLE: begin
          if (is_first_key) begin
            next_seq = prl_pkg::PRL_GOT_55;
          end else begin
            next_seq = prl_pkg::PRL_IDLE;
          end
        end
        prl_pkg::PRL_GOT_55: begin
          if (is_second_key) begin
            next_seq = prl_pkg::PRL_ARMED;
          end else if (is_first_key) begin
            next_seq = prl_pkg::PRL_GOT_55;
          end else begin
            next_seq = prl_pkg::PRL_IDLE;
          end
        end
        prl_pkg::PRL_ARMED: begin
          // armed lasts for exactly one following write
          if (is_first_key) begin
            next_seq = prl_pkg::PRL_GOT_55;
          end else begin
            next_seq = prl_pkg::PRL_IDLE;
          end
        end
        // code 11 is unused and only reachable by an upset
        default: begin
          next_seq = prl_pkg::PRL_IDLE;
        end
      endcase
    end
  end

  // a half-entered sequence must not survive any reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq <= prl_pkg::PRL_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  // one-way: fresh -> cleared -> spent, held until reset
  assign may_clear  = !one_way_en || ow == prl_pkg::PRL_OW_FRESH;
  assign may_set    = !one_way_en || ow != prl_pkg::PRL_OW_SPENT;
  // full-register writes never touch the flag
  assign flag_op_ok = seq == prl_pkg::PRL_ARMED && bit0_only(lock_wr.data);

  always_comb begin
    next_flag = routing_lock_flag;
    if (flag_op_ok) begin
      if (lock_wr.bit_set && may_set) begin
        next_flag = 1'b1;
      end else if (lock_wr.bit_clr && may_clear) begin
        next_flag = 1'b0;
      end
    end
  end

  // flag comes up unlocked after any reset; por is always paired
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      routing_lock_flag <= `PRL_FLAG_RESET;
    end else begin
      routing_lock_flag <= next_flag;
    end
  end

  // set before any clear is allowed and does not spend the option
  always_comb begin
    next_ow = ow;
    if (flag_op_ok && one_way_en) begin
      if (lock_wr.bit_set && may_set) begin
        if (ow == prl_pkg::PRL_OW_CLEARED) begin
          next_ow = prl_pkg::PRL_OW_SPENT;
        end
      end else if (lock_wr.bit_clr && may_clear) begin
        next_ow = prl_pkg::PRL_OW_CLEARED;
      end
    end
  end

  // any device reset rearms the one-way option
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ow <= prl_pkg::PRL_OW_FRESH;
    end else begin
      ow <= next_ow;
    end
  end

  // lock freezes every selection write
  always_comb begin
    sel_ok       = sel_wr.wr && !routing_lock_flag;
    next_refused = sel_wr.wr && routing_lock_flag;
    in_wr        = sel_ok && !sel_wr.is_out;
    out_wr       = sel_ok && sel_wr.is_out;
  end

  // refusal is a one-cycle pulse, so nothing has to clear it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sel_write_refused <= 1'b0;
    end else begin
      sel_write_refused <= next_refused;
    end
  end

  // any selection code accepted for any signal, incl. bus pins
  // same bank type for input and output so a bidir peripheral can
  // name one pin twice; matching them is software's job
  // banks reset on por only, so warm resets keep the routing
  prl_sel_bank u_in_bank (
    .clock    (clock),
    .por_n    (por_n),
    .wr       (in_wr),
    .idx      (sel_wr.idx),
    .data     (sel_wr.data),
    .sel_flat (in_sel)
  );

  prl_sel_bank u_out_bank (
    .clock    (clock),
    .por_n    (por_n),
    .wr       (out_wr),
    .idx      (sel_wr.idx),
    .data     (sel_wr.data),
    .sel_flat (out_sel)
  );
endmodule : prl_lock

// ==== logic/prl_pkg.sv ====
// types shared by the pin routing lock block
// assumes prl_defines.svh is on the include path
`include "prl_defines.svh"
package prl_pkg;
  typedef enum logic [1:0] {
    PRL_IDLE   = 2'b00,
    PRL_GOT_55 = 2'b01,
    PRL_ARMED  = 2'b10
  } prl_seq_t;
  typedef enum logic [1:0] {
    PRL_OW_FRESH   = 2'b00,
    PRL_OW_CLEARED = 2'b01,
    PRL_OW_SPENT   = 2'b10
  } prl_ow_t;
  // one write from the core to the lock register
  typedef struct packed {
    logic       full_wr;
    logic       bit_set;
    logic       bit_clr;
    logic [7:0] data;
  } prl_lock_wr_t;
  // one write to a routing selection
  typedef struct packed {
    logic                        wr;
    logic                        is_out;
    logic [`PRL_IN_SEL_W-1:0]    idx;
    logic [`PRL_SEL_WIDTH-1:0]   data;
  } prl_sel_wr_t;
endpackage : prl_pkg

// ==== logic/prl_sel_bank.sv ====
// bank of routing selection registers
// reset only by power-on; writes gated by the lock flag upstream
`timescale 1ns/1ps
`include "prl_defines.svh"
module prl_sel_bank (
  input  wire logic                      clock,
  input  wire logic                      por_n,
  input  wire logic                      wr,
  input  wire logic [`PRL_IN_SEL_W-1:0]  idx,
  input  wire logic [`PRL_SEL_WIDTH-1:0] data,
  output logic [`PRL_IN_SEL_W*`PRL_SEL_WIDTH-1:0] sel_flat
);
  logic [`PRL_SEL_WIDTH-1:0] sel      [`PRL_NUM_IN];
  logic [`PRL_SEL_WIDTH-1:0] next_sel [`PRL_NUM_IN];

  always_comb begin
    for (int i = 0; i < `PRL_NUM_IN; i++) begin
      next_sel[i] = sel[i];
    end
    if (wr) begin
      next_sel[idx] = data;
    end
  end

  // only power-on clears; other resets keep values
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < `PRL_NUM_IN; i++) begin
        sel[i] <= `PRL_SEL_DEFAULT;
      end
    end else begin
      for (int i = 0; i < `PRL_NUM_IN; i++) begin
        sel[i] <= next_sel[i]; // sleep does not touch these
      end
    end
  end

  always_comb begin
    sel_flat = '0;
    for (int i = 0; i < `PRL_IN_SEL_W; i++) begin
      sel_flat[i*`PRL_SEL_WIDTH +: `PRL_SEL_WIDTH] = sel[i];
    end
  end
endmodule : prl_sel_bank

// ==== testbench/prl_lock_assertions.sv ====
// port checker for the pin routing lock
// bound into prl_lock below; sees only its ports
`timescale 1ns/1ps
`include "prl_defines.svh"
module prl_lock_chk (
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire logic                  por_n,
  input wire prl_pkg::prl_lock_wr_t lock_wr,
  input wire prl_pkg::prl_sel_wr_t  sel_wr,
  input wire logic                  routing_lock_flag,
  input wire logic                  sel_write_refused,
  input wire logic [23:0]           in_sel,
  input wire logic [23:0]           out_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire f = routing_lock_flag;
  wire w = sel_wr.wr;
  property p_frz; f && w |=> $stable({in_sel, out_sel}); endproperty
  a_frz: assert property (p_frz) else $error("locked sel moved");
  property p_ref; f && w |=> sel_write_refused; endproperty
  a_ref: assert property (p_ref) else $error("no refusal");
  property p_nrf; !(f && w) |=> !sel_write_refused; endproperty
  a_nrf: assert property (p_nrf) else $error("stray refusal");
  property p_ful; lock_wr.full_wr |=> $stable(f); endproperty
  a_ful: assert property (p_ful) else $error("full write moved");
  property p_set; $rose(f) |-> $past(lock_wr.bit_set); endproperty
  a_set: assert property (p_set) else $error("set w/o bit op");
  property p_clr; $fell(f) |-> $past(lock_wr.bit_clr); endproperty
  a_clr: assert property (p_clr) else $error("clr w/o bit op");
  // plain resets must not touch the selections, only power-on does
  property p_kp; disable iff (!por_n) !w |=> $stable({in_sel, out_sel});
  endproperty
  a_kp: assert property (p_kp) else $error("sel moved");
  property p_por; disable iff (1'b0) !por_n |-> {in_sel, out_sel} == 0;
  endproperty
  a_por: assert property (p_por) else $error("por kept sel");
endmodule : prl_lock_chk
bind prl_lock prl_lock_chk i_chk (.clock, .resetn, .por_n, .lock_wr,
  .sel_wr, .routing_lock_flag, .sel_write_refused, .in_sel, .out_sel);

// ==== testbench/tb_pin_routing_lock.sv ====
// bench for pin routing lock: a model is compared at every result
// assumes prl_defines.svh on the include path
`timescale 1ns/1ps
`include "prl_defines.svh"
`define CK(n,e,g) begin compares++; if ((g)!==(e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_pin_routing_lock;
  logic clock = 0, resetn = 1, por_n = 1, one_way_en = 0, fl = 0;
  prl_pkg::prl_lock_wr_t lock_wr = '0;
  prl_pkg::prl_sel_wr_t  sel_wr  = '0;
  logic flag, refused;
  logic [23:0] in_sel, out_sel, ei = 0, eo = 0;
  int n_fail = 0, compares = 0, cyc = 0, seed = 11, st = 0, ow = 0;
  always #12.5 clock = ~clock;
  prl_lock i_dut (.clock, .resetn, .por_n, .one_way_en, .lock_wr,
    .sel_wr, .routing_lock_flag(flag), .sel_write_refused(refused),
    .in_sel, .out_sel);
  task automatic summarize;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      summarize;
    end
  end
  // k: 0 full write, 1 bit set, 2 bit clear
  task automatic lw(input int k, input logic [7:0] d);
    @(posedge clock) lock_wr <= {k == 0, k == 1, k == 2, d};
    @(posedge clock) lock_wr <= '0;
    #1;
    if (k == 0) st = (d == 8'h55) ? 1 : (st == 1 && d == 8'hAA) ? 2 : 0;
    else if (st == 2 && d == 8'h01) begin
      if (k == 1 && !fl) begin
        fl = 1;
        ow = (ow == 1) ? 2 : ow;
      end
      if (k == 2 && fl && ow != 2) begin
        fl = 0;
        ow = one_way_en;
      end
    end
    if (k != 0) st = 0;
    `CK("flag", fl, flag)
  endtask : lw
  // keys one idle cycle apart, as software does with irqs masked
  task automatic seq(input int k, input logic stray);
    lw(0, 8'h55);
    lw(0, 8'hAA);
    if (stray) lw(0, 8'h12);
    lw(k, 8'h01);
  endtask : seq
  task automatic sw(input logic o, input logic [3:0] i);
    logic [5:0] d;
    d = 6'($random(seed));
    @(posedge clock) sel_wr <= {1'b1, o, i, d};
    @(posedge clock) sel_wr <= '0;
    #1;
    if (!fl && i < 4 && o) eo[i*6+:6] = d;
    if (!fl && i < 4 && !o) ei[i*6+:6] = d;
    `CK("refused", fl, refused)
    `CK("in_sel", ei, in_sel)
    `CK("out_sel", eo, out_sel)
  endtask : sw
  task automatic rst(input logic p);
    @(posedge clock) resetn <= 0;
    por_n <= !p;
    repeat (3) @(posedge clock);
    resetn <= 1;
    por_n <= 1;
    #1;
    {fl, st, ow} = 0;
    if (p) {ei, eo} = 0;
    `CK("flag", fl, flag)
    `CK("sel", {ei, eo}, {in_sel, out_sel})
  endtask : rst
  initial begin
    rst(1);
    for (int i = 0; i < 6; i++) sw(i[0], 4'(i)); // both banks
    $display("test unlocked done");
    seq(1, 0);
    sw(1'b0, 4'h1);
    sw(1'b1, 4'h2);
    seq(2, 1);
    seq(0, 0);
    seq(2, 0);
    sw(1'b0, 4'h3);
    $display("test lock done");
    @(posedge clock) one_way_en <= 1;
    rst(0);
    for (int i = 0; i < 4; i++) seq(i[0] ? 2 : 1, 0);
    sw(1'b1, 4'h0);
    rst(0);
    seq(1, 0);
    seq(2, 0);
    $display("test one-way done");
    rst(1);
    $display("test power-on done");
    summarize;
  end
endmodule : tb_pin_routing_lock
